//--- rtl/spf_pkg.sv
package spf_pkg;
   localparam int PORT_CNT = 3;
   // register offsets on the serial register port
   localparam logic [7:0] OFF_P1_CTRL_A = 8'h11;
   localparam logic [7:0] OFF_P1_CTRL_B = 8'h12;
   localparam logic [7:0] OFF_P2_CTRL_A = 8'h21;
   localparam logic [7:0] OFF_P2_CTRL_B = 8'h22;
   localparam logic [7:0] OFF_P3_CTRL_A = 8'h31;
   localparam logic [7:0] OFF_P3_CTRL_B = 8'h32;
   // control a fields
   localparam int A_SNIFFER = 7;
   localparam int A_RX_SNIFF = 6;
   localparam int A_TX_SNIFF = 5;
   localparam int A_DBL_TAG = 4;
   localparam int A_PRIO_CEIL = 3;
   localparam int A_MEMB_HI = 2;
   localparam int A_MEMB_LO = 0;
   // control b fields
   localparam int B_RSVD = 7;
   localparam int B_VLAN_FILT = 6;
   localparam int B_NON_PORT_DEFAULT_VLAN_ID_DROP = 5;
   localparam int B_FORCE_FC = 4;
   localparam int B_BACKPR = 3;
   localparam int B_TX_EN = 2;
   localparam int B_RX_EN = 1;
   localparam int B_LEARN_DIS = 0;
   // reset values; b bit 4 is replaced by the strap where one exists
   localparam logic [7:0] CTRL_A_RST = 8'h07;
   localparam logic [7:0] CTRL_B_RST = 8'h06;
   localparam logic [7:0] RDATA_IDLE = 8'h00;
   // default tag layout
   localparam int TAG_PRIO_HI = 15;
   localparam int TAG_PRIO_LO = 13;
   localparam int TAG_CFI = 12;
   localparam int TAG_VID_HI = 11;

   // offset of a port's control a (sel_b=0) or control b (sel_b=1)
   function automatic logic [7:0] reg_offset(input int port, input logic sel_b);
      case (port)
         0: reg_offset = sel_b ? OFF_P1_CTRL_B : OFF_P1_CTRL_A;
         1: reg_offset = sel_b ? OFF_P2_CTRL_B : OFF_P2_CTRL_A;
         2: reg_offset = sel_b ? OFF_P3_CTRL_B : OFF_P3_CTRL_A;
         default: reg_offset = 8'hff;
      endcase
   endfunction
endpackage

//--- rtl/spf_cfg_shadow.sv
`timescale 1ns/1ps
`default_nettype none
module spf_cfg_shadow
   import spf_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic frame_busy,
   input wire logic [7:0] live_a,
   input wire logic [7:0] live_b,
   output logic [7:0] act_a_r,
   output logic [7:0] act_b_r
);
   logic [7:0] act_a_nxt;
   logic [7:0] act_b_nxt;

   // settings reach the frame logic only between frames or in reset, so a frame
   // already in flight never sees a half-changed configuration
   always_comb begin
      act_a_nxt = act_a_r;
      act_b_nxt = act_b_r;
      if (!rst_b || !frame_busy) begin // [R19]
         act_a_nxt = live_a;
         act_b_nxt = live_b;
      end
   end

   always_ff @(posedge mclk) begin
      act_a_r <= act_a_nxt;
      act_b_r <= act_b_nxt;
   end

   a_frame_hold: assert property (@(posedge mclk) disable iff (!rst_b) // [R19]
      (frame_busy && $past(frame_busy)) |-> ($stable(act_a_r) && $stable(act_b_r)))
      else $error("active config changed inside a frame");
endmodule // spf_cfg_shadow
`default_nettype wire

//--- rtl/spf_ingress_check.sv
`timescale 1ns/1ps
`default_nettype none
module spf_ingress_check
   import spf_pkg::*;
#(
   parameter int PORT_IDX = 0
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [7:0] act_a,
   input wire logic [7:0] act_b,
   input wire logic [15:0] default_tag,
   input wire logic [11:0] rx_vid,
   input wire logic [2:0] rx_prio,
   input wire logic [2:0] vlan_memb,
   output logic drop_r,
   output logic [2:0] prio_r
);
   logic drop_nxt;
   logic [2:0] prio_nxt;
   logic [2:0] tag_prio;

   // tag priority sits in the top three bits of the default tag
   assign tag_prio = default_tag[TAG_PRIO_HI:TAG_PRIO_LO]; // [R18]

   // drop and priority decision for the frame at ingress
   always_comb begin
      drop_nxt = !act_b[B_RX_EN]; // [R13]
      if (act_b[B_VLAN_FILT] && !vlan_memb[PORT_IDX]) drop_nxt = 1'b1; // [R7]
      if (act_b[B_NON_PORT_DEFAULT_VLAN_ID_DROP] && rx_vid != default_tag[TAG_VID_HI:0]) begin // [R8]
         drop_nxt = 1'b1;
      end
      prio_nxt = rx_prio;
      if (act_a[A_PRIO_CEIL] && rx_prio > tag_prio) prio_nxt = tag_prio; // [R5]
      if (!rst_b) begin
         drop_nxt = 1'b0;
         prio_nxt = 3'h0;
      end
   end

   always_ff @(posedge mclk) begin
      drop_r <= drop_nxt;
      prio_r <= prio_nxt;
   end

   a_prio_ceil: assert property (@(posedge mclk) disable iff (!rst_b) // [R5]
      act_a[A_PRIO_CEIL] |=> prio_r <= $past(tag_prio))
      else $error("priority above ceiling passed through");
   a_vlan_filt: assert property (@(posedge mclk) disable iff (!rst_b) // [R7]
      (act_b[B_VLAN_FILT] && !vlan_memb[PORT_IDX]) |=> drop_r)
      else $error("frame outside vlan not dropped");
   a_port_default_vlan_id_drop: assert property (@(posedge mclk) disable iff (!rst_b) // [R8]
      (!act_b[B_NON_PORT_DEFAULT_VLAN_ID_DROP] && !act_b[B_VLAN_FILT] && act_b[B_RX_EN]) |=> !drop_r)
      else $error("frame dropped with all filters off");
   a_port_default_vlan_id_mismatch: assert property (@(posedge mclk) disable iff (!rst_b) // [R8]
      (act_b[B_NON_PORT_DEFAULT_VLAN_ID_DROP] && rx_vid != default_tag[TAG_VID_HI:0]) |=> drop_r)
      else $error("frame off default vid not dropped");
endmodule // spf_ingress_check
`default_nettype wire

//--- rtl/spf_forward_ctrl.sv
// Function
// [R1] sniffer bit makes port the mirror destination
// [R2] receive sniff mirrors all received frames
// [R3] transmit sniff mirrors all transmitted frames
// [R4] double tag adds ingress default tag always
// [R5] ceiling clamps frame priority to tag priority
// [R6] egress membership bits, reset all ones
// [R7] ingress vlan filter drops non-member frames
// [R8] drop frames whose vid differs from default
// [R9] force pause flow control; port three ignores
// [R10] ports one, two load force bit from strap
// [R11] back pressure enable, reset zero
// [R12] transmit enable, reset one
// [R13] receive enable, reset one
// [R14] learning disable stops source address learning
// [R15] software builds spanning tree states from bits
// [R16] host keeps reserved bit at zero
// [R17] control a per port at 11, 21, 31
// [R18] default tag: priority, canonical flag, vid
// [R19] changes apply only to frames starting later
`timescale 1ns/1ps
`default_nettype none
module spf_forward_ctrl
   import spf_pkg::*;
(
   input wire logic MCLK,
   input wire logic RST_B,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   output logic [7:0] REG_RDATA,
   output logic REG_RVALID,
   input wire logic PORT_ONE_FLOWCTL_STRAP,
   input wire logic PORT_TWO_FLOWCTL_STRAP,
   input wire logic [2:0] FRAME_BUSY,
   input wire logic [2:0] AN_PAUSE_OK,
   input wire logic [47:0] DEFAULT_TAG,
   input wire logic [35:0] RX_VID,
   input wire logic [8:0] RX_PRIO,
   input wire logic [8:0] VLAN_TBL_MEMB,
   input wire logic [2:0] EGRESS_SEL,
   output logic [2:0] SNIFFER_MASK,
   output logic [2:0] RX_MONITOR,
   output logic [2:0] TX_MONITOR,
   output logic [2:0] DOUBLE_TAG_EN,
   output logic [8:0] EGRESS_MEMBERSHIP,
   output logic [2:0] PAUSE_FC_EN,
   output logic [2:0] BACKPRESSURE_EN,
   output logic [2:0] TX_ENABLE,
   output logic [2:0] RX_ENABLE,
   output logic [2:0] LEARN_ENABLE,
   output logic [2:0] INGRESS_DROP,
   output logic [8:0] OUT_PRIO
);
   // software-visible copies, updated on register writes
   logic [7:0] ctrl_a_r [PORT_CNT];
   logic [7:0] ctrl_b_r [PORT_CNT];
   logic [7:0] ctrl_a_nxt [PORT_CNT];
   logic [7:0] ctrl_b_nxt [PORT_CNT];
   // copies that the frame logic actually uses
   logic [7:0] act_a [PORT_CNT];
   logic [7:0] act_b [PORT_CNT];
   // strap synchronisers
   logic [1:0] strap_s1_r;
   logic [1:0] strap_s2_r;
   logic [1:0] strap_s1_nxt;
   logic [1:0] strap_s2_nxt;
   // read path
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;
   logic rvalid_r;
   logic rvalid_nxt;
   // registered control outputs
   logic [2:0] sniff_r;
   logic [2:0] rx_mon_r;
   logic [2:0] tx_mon_r;
   logic [2:0] dbl_r;
   logic [8:0] memb_r;
   logic [2:0] fc_r;
   logic [2:0] bp_r;
   logic [2:0] txen_r;
   logic [2:0] rxen_r;
   logic [2:0] learn_r;
   logic [2:0] sniff_nxt;
   logic [2:0] rx_mon_nxt;
   logic [2:0] tx_mon_nxt;
   logic [2:0] dbl_nxt;
   logic [8:0] memb_nxt;
   logic [2:0] fc_nxt;
   logic [2:0] bp_nxt;
   logic [2:0] txen_nxt;
   logic [2:0] rxen_nxt;
   logic [2:0] learn_nxt;

   // straps are pins, so two flops before anything looks at them
   always_comb begin
      strap_s1_nxt = {PORT_TWO_FLOWCTL_STRAP, PORT_ONE_FLOWCTL_STRAP};
      strap_s2_nxt = strap_s1_r;
   end

   always_ff @(posedge MCLK) begin
      strap_s1_r <= strap_s1_nxt;
      strap_s2_r <= strap_s2_nxt;
   end

   genvar p;
   generate
      for (p = 0; p < PORT_CNT; p++) begin : g_port
         // register writes; reset loads defaults, strap on ports one and two
         always_comb begin
            ctrl_a_nxt[p] = ctrl_a_r[p];
            ctrl_b_nxt[p] = ctrl_b_r[p];
            if (!RST_B) begin
               ctrl_a_nxt[p] = CTRL_A_RST; // [R6]
               ctrl_b_nxt[p] = CTRL_B_RST; // [R11] [R12] [R13]
               if (p < 2) begin
                  // the strap is resampled on every reset cycle, so the
                  // level seen just before release is the one kept
                  ctrl_b_nxt[p][B_FORCE_FC] = strap_s2_r[p]; // [R10]
               end
            end else if (REG_WR) begin
               if (REG_ADDR == reg_offset(p, 1'b0)) begin // [R17]
                  ctrl_a_nxt[p] = REG_WDATA;
               end
               // reserved bit is stored as written; keeping it zero is software's job
               if (REG_ADDR == reg_offset(p, 1'b1)) begin // [R16]
                  ctrl_b_nxt[p] = REG_WDATA;
               end
            end
         end

         always_ff @(posedge MCLK) begin
            ctrl_a_r[p] <= ctrl_a_nxt[p];
            ctrl_b_r[p] <= ctrl_b_nxt[p];
         end

         spf_cfg_shadow u_shadow (
            .mclk(MCLK),
            .rst_b(RST_B),
            .frame_busy(FRAME_BUSY[p]),
            .live_a(ctrl_a_r[p]),
            .live_b(ctrl_b_r[p]),
            .act_a_r(act_a[p]),
            .act_b_r(act_b[p])
         );

         spf_ingress_check #(
            .PORT_IDX(p)
         ) u_check (
            .mclk(MCLK),
            .rst_b(RST_B),
            .act_a(act_a[p]),
            .act_b(act_b[p]),
            .default_tag(DEFAULT_TAG[p*16 +: 16]),
            .rx_vid(RX_VID[p*12 +: 12]),
            .rx_prio(RX_PRIO[p*3 +: 3]),
            .vlan_memb(VLAN_TBL_MEMB[p*3 +: 3]),
            .drop_r(INGRESS_DROP[p]),
            .prio_r(OUT_PRIO[p*3 +: 3])
         );

         // per-port control decode from the active copy
         always_comb begin
            sniff_nxt[p] = act_a[p][A_SNIFFER]; // [R1]
            rx_mon_nxt[p] = act_a[p][A_RX_SNIFF]; // [R2]
            // a transmit-sniffed port marks only frames headed out on it
            tx_mon_nxt[p] = act_a[p][A_TX_SNIFF] && EGRESS_SEL[p]; // [R3]
            dbl_nxt[p] = act_a[p][A_DBL_TAG]; // [R4]
            memb_nxt[p*3 +: 3] = act_a[p][A_MEMB_HI:A_MEMB_LO]; // [R6]
            // port three has no force bit; pause follows negotiation only
            if (p < 2) begin
               fc_nxt[p] = act_b[p][B_FORCE_FC] || AN_PAUSE_OK[p]; // [R9]
            end else begin
               fc_nxt[p] = AN_PAUSE_OK[p]; // [R9]
            end
            bp_nxt[p] = act_b[p][B_BACKPR]; // [R11]
            txen_nxt[p] = act_b[p][B_TX_EN]; // [R12] [R15]
            rxen_nxt[p] = act_b[p][B_RX_EN]; // [R13] [R15]
            learn_nxt[p] = !act_b[p][B_LEARN_DIS]; // [R14] [R15]
         end

         // each output checked both ways, so a stuck-high or stuck-low flop is caught
         a_sniff_dest: assert property (@(posedge MCLK) disable iff (!RST_B) // [R1]
            act_a[p][A_SNIFFER] |=> SNIFFER_MASK[p])
            else $error("sniffer port not flagged");
         a_sniff_clear: assert property (@(posedge MCLK) disable iff (!RST_B) // [R1]
            !act_a[p][A_SNIFFER] |=> !SNIFFER_MASK[p])
            else $error("normal port flagged as sniffer");
         a_rx_mon: assert property (@(posedge MCLK) disable iff (!RST_B) // [R2]
            $past(RST_B) |-> RX_MONITOR[p] == $past(act_a[p][A_RX_SNIFF]))
            else $error("receive monitor flag wrong");
         a_tx_mon: assert property (@(posedge MCLK) disable iff (!RST_B) // [R3]
            !act_a[p][A_TX_SNIFF] |=> !TX_MONITOR[p])
            else $error("transmit monitor set while off");
         a_tx_mon_on: assert property (@(posedge MCLK) disable iff (!RST_B) // [R3]
            (act_a[p][A_TX_SNIFF] && EGRESS_SEL[p]) |=> TX_MONITOR[p])
            else $error("transmitted frame not monitored");
         a_dbl_tag: assert property (@(posedge MCLK) disable iff (!RST_B) // [R4]
            act_a[p][A_DBL_TAG] |=> DOUBLE_TAG_EN[p])
            else $error("double tag not enabled");
         a_dbl_off: assert property (@(posedge MCLK) disable iff (!RST_B) // [R4]
            !act_a[p][A_DBL_TAG] |=> !DOUBLE_TAG_EN[p])
            else $error("double tag on while off");
         a_memb_reset: assert property (@(posedge MCLK) // [R6]
            $rose(RST_B) |-> ctrl_a_r[p][A_MEMB_HI:A_MEMB_LO] == 3'h7)
            else $error("membership not all ones after reset");
         a_memb_out: assert property (@(posedge MCLK) disable iff (!RST_B) // [R6]
            RST_B [*2] |-> EGRESS_MEMBERSHIP[p*3 +: 3] == $past(act_a[p][2:0]))
            else $error("egress membership mismatch");
         a_b_reset: assert property (@(posedge MCLK) // [R11]
            $rose(RST_B) |-> ctrl_b_r[p][3:0] == 4'h6 && !ctrl_b_r[p][B_RSVD])
            else $error("control b reset value wrong");
         a_bp_on: assert property (@(posedge MCLK) disable iff (!RST_B) // [R11]
            act_b[p][B_BACKPR] |=> BACKPRESSURE_EN[p])
            else $error("back pressure not enabled");
         a_back_press: assert property (@(posedge MCLK) disable iff (!RST_B) // [R11]
            act_b[p][B_BACKPR] != $past(act_b[p][B_BACKPR])
            |=> BACKPRESSURE_EN[p] != $past(BACKPRESSURE_EN[p]))
            else $error("back pressure did not follow");
         a_tx_gate: assert property (@(posedge MCLK) disable iff (!RST_B) // [R12]
            !act_b[p][B_TX_EN] |=> !TX_ENABLE[p])
            else $error("transmit not blocked");
         a_tx_open: assert property (@(posedge MCLK) disable iff (!RST_B) // [R12]
            act_b[p][B_TX_EN] |=> TX_ENABLE[p])
            else $error("transmit not permitted");
         a_rx_gate: assert property (@(posedge MCLK) disable iff (!RST_B) // [R13]
            !act_b[p][B_RX_EN] ##1 RST_B |-> !RX_ENABLE[p] && INGRESS_DROP[p])
            else $error("reception not blocked");
         a_rx_open: assert property (@(posedge MCLK) disable iff (!RST_B) // [R13]
            act_b[p][B_RX_EN] |=> RX_ENABLE[p])
            else $error("reception not permitted");
         a_learn_off: assert property (@(posedge MCLK) disable iff (!RST_B) // [R14]
            act_b[p][B_LEARN_DIS] |=> !LEARN_ENABLE[p])
            else $error("learning not disabled");
         a_learn_on: assert property (@(posedge MCLK) disable iff (!RST_B) // [R14]
            !act_b[p][B_LEARN_DIS] |=> LEARN_ENABLE[p])
            else $error("learning not enabled");

         a_write_land: assert property (@(posedge MCLK) disable iff (!RST_B) // [R17]
            (REG_WR && REG_ADDR == reg_offset(p, 1'b0)) |=> ctrl_a_r[p] == $past(REG_WDATA))
            else $error("control a write lost");
         a_write_b_land: assert property (@(posedge MCLK) disable iff (!RST_B) // [R16]
            (REG_WR && REG_ADDR == reg_offset(p, 1'b1)) |=> ctrl_b_r[p] == $past(REG_WDATA))
            else $error("control b write lost");
         a_idle_apply: assert property (@(posedge MCLK) disable iff (!RST_B) // [R19]
            (REG_WR && REG_ADDR == reg_offset(p, 1'b1)) ##1 !FRAME_BUSY[p]
            |=> act_b[p] == $past(ctrl_b_r[p]))
            else $error("idle port did not take new setting");
         // pause: forced bit or negotiation on ports one and two, negotiation only on three
         if (p < 2) begin : g_strap
            a_strap_load: assert property (@(posedge MCLK) // [R10]
               $rose(RST_B) |-> ctrl_b_r[p][B_FORCE_FC] == $past(strap_s2_r[p]))
               else $error("force flow bit not loaded from strap");
            a_force_fc: assert property (@(posedge MCLK) disable iff (!RST_B) // [R9]
               act_b[p][B_FORCE_FC] |=> PAUSE_FC_EN[p])
               else $error("forced pause not enabled");
            a_fc_follow: assert property (@(posedge MCLK) disable iff (!RST_B) // [R9]
               (!act_b[p][B_FORCE_FC] && !AN_PAUSE_OK[p]) |=> !PAUSE_FC_EN[p])
               else $error("pause on without force or negotiation");
         end else begin : g_nostrap
            a_fc_an_only: assert property (@(posedge MCLK) disable iff (!RST_B) // [R9]
               !AN_PAUSE_OK[p] |=> !PAUSE_FC_EN[p])
               else $error("port three pause without negotiation");
            a_fc_an_on: assert property (@(posedge MCLK) disable iff (!RST_B) // [R9]
               AN_PAUSE_OK[p] |=> PAUSE_FC_EN[p])
               else $error("port three pause not following negotiation");
         end
      end
   endgenerate

   // control outputs are registered; reset shows the default setting, except pause, which reset holds off whatever the straps
   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         sniff_r <= 3'h0;
         rx_mon_r <= 3'h0;
         tx_mon_r <= 3'h0;
         dbl_r <= 3'h0;
         memb_r <= 9'h1ff;
         fc_r <= 3'h0;
         bp_r <= 3'h0;
         txen_r <= 3'h7;
         rxen_r <= 3'h7;
         learn_r <= 3'h7;
      end else begin
         sniff_r <= sniff_nxt;
         rx_mon_r <= rx_mon_nxt;
         tx_mon_r <= tx_mon_nxt;
         dbl_r <= dbl_nxt;
         memb_r <= memb_nxt;
         fc_r <= fc_nxt;
         bp_r <= bp_nxt;
         txen_r <= txen_nxt;
         rxen_r <= rxen_nxt;
         learn_r <= learn_nxt;
      end
   end

   assign SNIFFER_MASK = sniff_r;
   assign RX_MONITOR = rx_mon_r;
   assign TX_MONITOR = tx_mon_r;
   assign DOUBLE_TAG_EN = dbl_r;
   assign EGRESS_MEMBERSHIP = memb_r;
   assign PAUSE_FC_EN = fc_r;
   assign BACKPRESSURE_EN = bp_r;
   assign TX_ENABLE = txen_r;
   assign RX_ENABLE = rxen_r;
   assign LEARN_ENABLE = learn_r;

   // read returns the software copy one cycle after the strobe;
   // unmapped offsets read as zero so probing is harmless
   always_comb begin
      rdata_nxt = RDATA_IDLE;
      rvalid_nxt = REG_RD && RST_B;
      for (int i = 0; i < PORT_CNT; i++) begin
         if (REG_ADDR == reg_offset(i, 1'b0)) rdata_nxt = ctrl_a_r[i];
         if (REG_ADDR == reg_offset(i, 1'b1)) rdata_nxt = ctrl_b_r[i];
      end
      if (!REG_RD || !RST_B) rdata_nxt = RDATA_IDLE;
   end

   always_ff @(posedge MCLK) begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
   end

   assign REG_RDATA = rdata_r;
   assign REG_RVALID = rvalid_r;

   // an idle read port must stay quiet, or a host could take stale data
   a_read_back: assert property (@(posedge MCLK) disable iff (!RST_B) // [R17]
      (REG_RD && !REG_WR && REG_ADDR == OFF_P1_CTRL_A) |=> REG_RVALID && REG_RDATA == ctrl_a_r[0])
      else $error("control a read back wrong");
   a_read_p3: assert property (@(posedge MCLK) disable iff (!RST_B) // [R17]
      (REG_RD && !REG_WR && REG_ADDR == OFF_P3_CTRL_A) |=> REG_RVALID && REG_RDATA == ctrl_a_r[2])
      else $error("port three control a read back wrong");
   a_read_quiet: assert property (@(posedge MCLK) disable iff (!RST_B) // [R17]
      !REG_RD |=> !REG_RVALID && REG_RDATA == RDATA_IDLE)
      else $error("read port not quiet without a read");
endmodule // spf_forward_ctrl
`default_nettype wire

//--- verif/spf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module spf_host_model (
   input wire logic mclk,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata
);
   // bus quiet from time zero, no strobe before the bench calls op
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end

   // one request per call, held across the taking edge; calls chain back to back
   task automatic op(input bit wr, input bit rd, input logic [7:0] addr, input logic [7:0] d);
      @(negedge mclk);
      reg_wr = wr;
      reg_rd = rd;
      reg_addr = addr;
      reg_wdata = d;
      if (addr[3:0] == 4'h2) begin
         reg_wdata[7] = 1'b0; // reserved bit always written as zero
      end
   endtask

   // release: address and data flip so a stale value is never mistaken for live
   task automatic idle();
      @(negedge mclk);
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = ~reg_addr;
      reg_wdata = ~reg_wdata;
   endtask
endmodule // spf_host_model
`default_nettype wire

//--- verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic mclk, rst_b, strap1, strap2, reg_wr, reg_rd, reg_rvalid;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic [2:0] frame_busy, an_ok, egr_sel;
   logic [47:0] dflt_tag;
   logic [35:0] rx_vid;
   logic [8:0] rx_prio, vlan_memb, egr_memb, out_prio;
   logic [2:0] sniff, rx_mon, tx_mon, dbl_tag, pause, bp, tx_en, rx_en, learn, drop;
   logic [7:0] exp_r [6];
   logic [7:0] exp_q [$];
   int err_count = 0;
   int check_count = 0;
   int cyc = 0;
   int unsigned seed_v;

   // 125 MHz
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   spf_forward_ctrl dut (.MCLK(mclk), .RST_B(rst_b), .REG_WR(reg_wr), .REG_RD(reg_rd),
      .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
      .REG_RVALID(reg_rvalid), .PORT_ONE_FLOWCTL_STRAP(strap1),
      .PORT_TWO_FLOWCTL_STRAP(strap2), .FRAME_BUSY(frame_busy), .AN_PAUSE_OK(an_ok),
      .DEFAULT_TAG(dflt_tag), .RX_VID(rx_vid), .RX_PRIO(rx_prio), .VLAN_TBL_MEMB(vlan_memb),
      .EGRESS_SEL(egr_sel), .SNIFFER_MASK(sniff), .RX_MONITOR(rx_mon), .TX_MONITOR(tx_mon),
      .DOUBLE_TAG_EN(dbl_tag), .EGRESS_MEMBERSHIP(egr_memb), .PAUSE_FC_EN(pause),
      .BACKPRESSURE_EN(bp), .TX_ENABLE(tx_en), .RX_ENABLE(rx_en), .LEARN_ENABLE(learn),
      .INGRESS_DROP(drop), .OUT_PRIO(out_prio));

   spf_host_model u_host (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata));

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // register access; a read notes the value held before any write of the same cycle
   task automatic acc(input int p, input bit sb, input bit wr, input bit rd, input logic [7:0] d);
      int i;
      i = p * 2 + int'(sb);
      if (rd) exp_q.push_back(exp_r[i]);
      if (wr) exp_r[i] = sb ? {1'b0, d[6:0]} : d;
      u_host.op(wr, rd, 8'((p + 1) * 16 + (sb ? 2 : 1)), d);
   endtask

   // every control output against the modelled registers and present inputs
   task automatic chk_outs();
      logic [7:0] a, b;
      logic [2:0] tp, rp;
      logic ex_d;
      for (int p = 0; p < 3; p++) begin
         a = exp_r[p * 2];
         b = exp_r[p * 2 + 1];
         tp = dflt_tag[p * 16 + 13 +: 3];
         rp = rx_prio[p * 3 +: 3];
         ex_d = !b[1] || (b[6] && !vlan_memb[p * 3 + p]);
         ex_d = ex_d || (b[5] && rx_vid[p * 12 +: 12] != dflt_tag[p * 16 +: 12]);
         chk(sniff[p], a[7], "sniffer");
         chk(rx_mon[p], a[6], "rx monitor");
         chk(tx_mon[p], a[5] & egr_sel[p], "tx monitor");
         chk(dbl_tag[p], a[4], "double tag");
         chk(out_prio[p * 3 +: 3], (a[3] && rp > tp) ? tp : rp, "prio ceiling");
         chk(egr_memb[p * 3 +: 3], a[2:0], "membership");
         chk(drop[p], ex_d, "ingress drop");
         chk(pause[p], (p < 2 && b[4]) | an_ok[p], "pause");
         chk(bp[p], b[3], "back pressure");
         chk(tx_en[p], b[2], "tx enable");
         chk(rx_en[p], b[1], "rx enable");
         chk(learn[p], !b[0], "learning");
      end
   endtask

   // read answers are matched in order against the notes
   always @(negedge mclk) begin
      if (reg_rvalid === 1'b1) begin
         if (exp_q.size() > 0) chk(reg_rdata, exp_q.pop_front(), "read data");
         else chk(reg_rvalid, 1'b0, "stray read valid");
      end
   end

   // a hang ends the run well past the few hundred cycles the tests need
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_count++;
         $display("ERROR t=%0t timeout", $time);
         results();
      end
   end

   initial begin
      seed_v = $urandom(32'hbb3bc6dc);
      rst_b = 1'b0;
      strap1 = 1'b1;
      strap2 = 1'b0;
      frame_busy = 3'b000;
      an_ok = 3'b000;
      egr_sel = 3'b000;
      dflt_tag = 48'h0;
      rx_vid = 36'h0;
      rx_prio = 9'h0;
      vlan_memb = 9'h0;
      for (int i = 0; i < 6; i++) exp_r[i] = i[0] ? 8'h06 : 8'h07;
      exp_r[1] = 8'h16; // port one force bit follows its strap
      repeat (10) @(negedge mclk);
      rst_b = 1'b1;
      repeat (2) @(negedge mclk);
      chk(pause, 3'b001, "strap pause");
      chk_outs();
      for (int i = 0; i < 6; i++) acc(i / 2, i[0], 1'b0, 1'b1, 8'h00);
      exp_q.push_back(8'h00);
      u_host.op(1'b1, 1'b1, 8'h13, 8'hff);
      u_host.idle();
      repeat (3) @(negedge mclk);
      $display("test reset_values done");
      for (int r = 0; r < 12; r++) begin
         an_ok = 3'($urandom);
         egr_sel = 3'($urandom);
         dflt_tag = {16'($urandom), 32'($urandom)};
         rx_prio = 9'($urandom);
         vlan_memb = 9'($urandom);
         for (int p = 0; p < 3; p++) begin
            rx_vid[p * 12 +: 12] = $urandom_range(1) ? dflt_tag[p * 16 +: 12] : 12'($urandom);
         end
         for (int i = 0; i < 6; i++) acc(i / 2, i[0], 1'b1, 1'b1, 8'($urandom));
         for (int i = 0; i < 6; i++) acc(i / 2, i[0], 1'b0, 1'b1, 8'h00);
         u_host.idle();
         repeat (4) @(negedge mclk);
         chk_outs();
      end
      $display("test random_config done");
      // second reset in mid-run with the straps swapped
      an_ok = 3'b000;
      rst_b = 1'b0;
      strap1 = 1'b0;
      strap2 = 1'b1;
      repeat (10) @(negedge mclk);
      rst_b = 1'b1;
      for (int i = 0; i < 6; i++) exp_r[i] = i[0] ? 8'h06 : 8'h07;
      exp_r[3] = 8'h16; // port two force bit now follows its strap
      repeat (2) @(negedge mclk);
      chk(pause, 3'b010, "strap pause again");
      chk_outs();
      $display("test reset_again done");
      acc(0, 1'b1, 1'b1, 1'b0, 8'h06);
      u_host.idle();
      repeat (4) @(negedge mclk);
      frame_busy = 3'b001;
      acc(0, 1'b1, 1'b1, 1'b0, 8'h01); // blocking state: no tx, no rx, no learning
      u_host.idle();
      repeat (4) @(negedge mclk);
      chk(tx_en[0], 1'b1, "frozen tx");
      chk(learn[0], 1'b1, "frozen learn");
      frame_busy = 3'b000;
      repeat (3) @(negedge mclk);
      chk_outs();
      chk(16'(exp_q.size()), 16'h0, "pending reads");
      $display("test busy_freeze done");
      results();
   end
endmodule // tb_top
`default_nettype wire
